/* File: verilog/tw_core.sv */
// How it works
// - Array holds 32768 bytes reached by one linear word address.
// - Up to 64 bytes of one page are committed in one write cycle.
// - Every internal write cycle ends within 5.0 ms of its start.
// - Write-guard high blocks all array writes; low or open allows them.
// - Three received slave-address bits compare against the three select pins.
// - Select pins are pulled low, so an open pin counts as zero.
// - Data line is only ever driven low; released otherwise.
// - Every location reads FF before anything is written.
// - Six check bits are kept per four-byte group.
// - Reads correct any single wrong bit in a group.
// - Partial group writes merge with stored bytes and recompute check bits.
// - The receiver of a byte pulls data low in the ninth clock.
// - No acknowledge at all while a write cycle runs.
// - Page write bumps only the low six address bits, wrapping.
// - Write-guard active withholds acknowledge after each write data byte.
`timescale 1ns/10ps
`include "tw_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module tw_fifo #(
  parameter int W = 23,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0]   cnt_q;
  logic          push, pop;

  // Handshakes
  assign in_ready  = cnt_q != (AW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage
  always_ff @(posedge mclk) begin
    if (push) mem_q[wp_q] <= in_data;
  end

  // Pointers and fill count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + AW'(1);
      if (pop) rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tw_fifo

////////////////////////////////////////////////////////////////////////////////
module tw_core
  import tw_pkg::*;
#(
  parameter int       WR_CYCLES = `TW_WR_CYCLES,
  parameter bit [3:0] DEV_CODE  = 4'h5  // Arbitrary value
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Two-wire bus
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // Straps and guard
  input  wire logic addr_select_pin_0,
  input  wire logic addr_select_pin_1,
  input  wire logic addr_select_pin_2,
  input  wire logic wp_i,
  // Status
  output logic      wr_busy
);
  // ECC code of data bit i: i-th nonzero six-bit value that is not a power of two
  function automatic tw_chk_t tw_code(input int i);
    int n;
    tw_code = '0;
    n = 0;
    for (int v = 3; v < 64; v++) begin
      if ((v & (v - 1)) != 0) begin
        if (n == i) tw_code = tw_chk_t'(v);
        n++;
      end
    end
  endfunction

  function automatic tw_chk_t tw_enc(input logic [31:0] d);
    tw_enc = '0;
    for (int i = 0; i < 32; i++) begin
      if (d[i]) tw_enc = tw_enc ^ tw_code(i);
    end
  endfunction

  function automatic logic [31:0] tw_fix(input logic [37:0] w);
    tw_chk_t syn;
    syn    = w[37:32] ^ tw_enc(w[31:0]);
    tw_fix = w[31:0];
    for (int i = 0; i < 32; i++) begin
      if (syn == tw_code(i)) tw_fix[i] = ~w[i];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each, then one history flop on clock and on data
  logic [5:0] s1_q, s2_q;
  logic       scl_p_q, sda_p_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q    <= 6'h03;
      s2_q    <= 6'h03;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      s1_q    <= {wp_i, addr_select_pin_2, addr_select_pin_1, addr_select_pin_0, sda_i, scl_i};
      s2_q    <= s1_q;
      scl_p_q <= s2_q[0];
      sda_p_q <= s2_q[1];
    end
  end

  // Bus events and strap decode
  logic       scl_s, sda_s, wp_s, rise, fall, start, stop;
  logic [2:0] pins_s;
  assign scl_s  = s2_q[0];
  assign sda_s  = s2_q[1];
  assign pins_s = s2_q[4:2];  // Open pins held low by pad pull-down
  assign wp_s   = s2_q[5];    // Open guard pin reads low
  assign rise   = scl_s & ~scl_p_q;
  assign fall   = ~scl_s & scl_p_q;
  assign start  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop   = scl_s & scl_p_q & ~sda_p_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Array with check bits, erased at power-up; the write port is its only process
  localparam tw_chk_t ERASED_CHK = tw_enc({4{`TW_ERASED}});
  logic [37:0] mem [`TW_GROUPS] = '{default: {ERASED_CHK, {4{`TW_ERASED}}}};

  tw_bus_e     st_q;
  tw_wr_e      wst_q;
  tw_addr_t    addr_q;
  logic [7:0]  sh_q, pb_q [`TW_PAGE_BYTES];
  logic [3:0]  cnt_q, grp_q;
  logic [8:0]  pg_q;
  logic [63:0] mask_q;
  logic [16:0] tmr_q;
  logic        ack_q, nack_q, pend_q, oe_q, busy_q;

  // Array read port and corrected data
  logic [12:0] rd_grp;
  logic [37:0] rd_raw;
  logic [31:0] cor_w, new_w;
  logic [7:0]  rd_byte;
  assign rd_grp  = (wst_q == W_COMMIT) ? {pg_q, grp_q[3:0]} : addr_q[14:2];
  assign rd_raw  = mem[rd_grp];
  assign cor_w   = tw_fix(rd_raw);
  assign rd_byte = cor_w[{addr_q[1:0], 3'h0} +: 8];

  // Merge of page bytes with stored group
  genvar b;
  for (b = 0; b < 4; b++) begin : g_merge
    assign new_w[8*b +: 8] = mask_q[{grp_q, 2'(b)}] ? pb_q[{grp_q, 2'(b)}]
                                                    : cor_w[8*b +: 8];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge decision and data path into the FIFO
  tw_wr_s     f_in, f_out;
  logic       f_in_rdy, f_out_val, f_pop, push, ack_ok, match, commit_en;
  logic       lastbit, ackbit;
  assign lastbit   = cnt_q == `TW_BIT_LAST;
  assign ackbit    = cnt_q == `TW_BIT_ACK;
  assign match     = sh_q[7:1] == {DEV_CODE, pins_s};
  assign ack_ok    = (st_q == ST_DEV) ? (match & ~busy_q)
                   : (st_q == ST_WD)  ? (~wp_s & f_in_rdy)
                   : (st_q == ST_AH) | (st_q == ST_AL);
  assign push      = (st_q == ST_WD) & fall & lastbit & ack_ok;
  assign f_in      = '{addr: addr_q, data: sh_q};
  assign f_pop     = (wst_q == W_IDLE) | (wst_q == W_FLUSH);
  assign commit_en = (wst_q == W_COMMIT) & (|mask_q[{grp_q, 2'h0} +: 4]);

  tw_fifo #(.W($bits(tw_wr_s)), .D(4)) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_data   (f_in),
    .in_valid  (push),
    .in_ready  (f_in_rdy),
    .out_data  (f_out),
    .out_valid (f_out_val),
    .out_ready (f_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial byte engine: shift, acknowledge, read data out
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE; cnt_q <= '0; sh_q <= '0; addr_q <= '0;
      ack_q <= 1'b0; nack_q <= 1'b0; oe_q <= 1'b0; pend_q <= 1'b0;
    end else if (start) begin
      st_q <= ST_DEV; cnt_q <= '0; oe_q <= 1'b0; ack_q <= 1'b0;
    end else if (stop) begin
      st_q <= ST_IDLE; cnt_q <= '0; oe_q <= 1'b0; pend_q <= 1'b0;
    end else if (st_q == ST_IDLE) begin
      oe_q <= 1'b0;
    end else if (rise && !ackbit) begin
      if (!lastbit) sh_q <= {sh_q[6:0], sda_s};
      cnt_q  <= cnt_q + 4'h1;
      nack_q <= sda_s;
    end else if (fall && lastbit) begin
      ack_q <= ack_ok;
      if (st_q == ST_RD) begin
        oe_q   <= 1'b0;                                   // Master acknowledges
        addr_q <= addr_q + 15'h1;
      end else begin
        oe_q <= ack_ok;                                   // Pull low in ninth clock
      end
      if (push) begin
        addr_q[5:0] <= addr_q[5:0] + 6'h1;                // Wrap inside page
        pend_q      <= 1'b1;
      end
    end else if (fall && ackbit) begin
      cnt_q <= '0;
      oe_q  <= 1'b0;
      case (st_q)
        ST_DEV:  begin
          st_q <= !ack_q ? ST_IDLE : (sh_q[0] ? ST_RD : ST_AH);
          oe_q <= ack_q & sh_q[0] & ~rd_byte[7];
        end
        ST_AH:   begin st_q <= ST_AL; addr_q[14:8] <= sh_q[6:0]; end
        ST_AL:   begin st_q <= ST_WD; addr_q[7:0] <= sh_q; end
        ST_RD:   begin
          st_q <= nack_q ? ST_IDLE : ST_RD;
          oe_q <= ~nack_q & ~rd_byte[7];
        end
        default: st_q <= ack_q ? st_q : ST_IDLE;
      endcase
    end else if (fall && st_q == ST_RD) begin
      oe_q <= ~rd_byte[3'h7 - cnt_q[2:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer fill from the FIFO
  always_ff @(posedge mclk) begin
    if (f_out_val && f_pop) pb_q[f_out.addr[5:0]] <= f_out.data;
  end

  // Array write, whole group with fresh check bits
  always_ff @(posedge mclk) begin
    if (commit_en) mem[rd_grp] <= {tw_enc(new_w), new_w};
  end

  // Internal write cycle sequencer
  logic wait_done;
  assign wait_done = tmr_q >= 17'(WR_CYCLES - 1);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wst_q <= W_IDLE; grp_q <= '0; pg_q <= '0; mask_q <= '0; tmr_q <= '0;
      busy_q <= 1'b0;
    end else begin
      if (f_out_val && f_pop) begin
        mask_q[f_out.addr[5:0]] <= 1'b1;
        pg_q <= f_out.addr[14:6];
      end
      tmr_q <= (wst_q == W_IDLE) ? '0 : tmr_q + 17'h1;
      case (wst_q)
        W_IDLE:   if (stop && pend_q) wst_q <= W_FLUSH;
        W_FLUSH:  if (!f_out_val) begin wst_q <= W_COMMIT; grp_q <= '0; end
        W_COMMIT: begin
          grp_q <= grp_q + 4'h1;                          // All groups of one page
          if (grp_q == 4'hf) begin
            wst_q  <= W_WAIT;
            mask_q <= '0;
          end
        end
        W_WAIT:   if (wait_done) wst_q <= W_IDLE;
        default:  wst_q <= W_IDLE;
      endcase
      busy_q <= (wst_q != W_IDLE) ? !(wst_q == W_WAIT && wait_done) : (stop && pend_q);
    end
  end

  // Output flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sda_o   <= 1'b0;
      sda_oe  <= 1'b0;
      wr_busy <= 1'b0;
    end else begin
      sda_o   <= 1'b0;                                    // Only ever low
      sda_oe  <= oe_q;
      wr_busy <= busy_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_sda_only_low:  assert property (sda_oe |-> sda_o == 1'b0)
    else $error("data line driven high");
  a_busy_no_ack:   assert property (busy_q && st_q == ST_DEV |-> !oe_q)
    else $error("acknowledge during write cycle");
  a_wr_time_max:   assert property (wst_q != W_IDLE |-> tmr_q < 17'(WR_CYCLES))
    else $error("write cycle too long");
  a_guard_no_ack:  assert property (st_q == ST_WD && fall && lastbit && wp_s
                                    |=> !oe_q)
    else $error("write data acknowledged under guard");
  a_guard_no_push: assert property (wp_s |-> !push)
    else $error("write accepted under guard");
  a_page_wrap:     assert property (push |=> addr_q[14:6] == $past(addr_q[14:6])
                                    && addr_q[5:0] == $past(addr_q[5:0]) + 6'h1)
    else $error("page address stepped wrongly");
  a_dev_ack:       assert property (st_q == ST_DEV && fall && lastbit && match
                                    && !busy_q |=> oe_q ##1 sda_oe)
    else $error("matching address not acknowledged");
  a_commit_end:    assert property (wst_q == W_COMMIT && grp_q == 4'hf
                                    |=> wst_q == W_WAIT && mask_q == '0)
    else $error("commit did not end after last group");
  a_group_check:   assert property (commit_en && !mask_q[{grp_q, 2'h0}]
                                    |-> new_w[7:0] == cor_w[7:0])
    else $error("stored byte lost in group merge");
  a_group_ecc:     assert property (commit_en |=> mem[$past(rd_grp)][37:32]
                                    == tw_enc(mem[$past(rd_grp)][31:0]))
    else $error("group check bits stale after write");
  a_read_fixed:    assert property (tw_enc(cor_w) == rd_raw[37:32]
                                    || rd_raw[37:32] != tw_enc(rd_raw[31:0]))
    else $error("clean group altered by correction");

  c_page_commit:   cover property (wst_q == W_COMMIT && grp_q == 4'hf);
  c_read_byte:     cover property (st_q == ST_RD && fall && lastbit);
  c_guard_refuse:  cover property (st_q == ST_WD && fall && lastbit && wp_s);
endmodule // tw_core

/* File: verilog/tw_regs.svh */
`ifndef TW_REGS_SVH
`define TW_REGS_SVH
// Array shape
`define TW_GROUPS        8192
`define TW_PAGE_BYTES    64
`define TW_ERASED        8'hff
// Serial byte framing: bits per byte, then the acknowledge clock
`define TW_BIT_LAST      4'h8
`define TW_BIT_ACK       4'h9
// Internal write cycle, longest time, in ns, and the sampling clock rate
`define TW_WR_TIME_NS    5000000
`define TW_CLK_MHZ       20
`define TW_WR_CYCLES     (`TW_WR_TIME_NS / 1000 * `TW_CLK_MHZ)
`endif

/* File: verilog/tw_pkg.sv */
package tw_pkg;
  typedef logic [14:0] tw_addr_t;
  typedef logic [5:0]  tw_chk_t;
  typedef struct packed {
    tw_addr_t    addr;
    logic [7:0]  data;
  } tw_wr_s;
  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_AH, ST_AL, ST_WD, ST_RD} tw_bus_e;
  typedef enum logic [1:0] {W_IDLE, W_FLUSH, W_COMMIT, W_WAIT} tw_wr_e;
endpackage

/* File: testbench/tw_master.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module tw_master (
  // Clock
  input  wire logic mclk,
  // Bus wires
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // Clock stands high, data released outside frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Quarter of the 400 ns bus period
  task automatic q();
    repeat (2) @(negedge mclk);
  endtask
  // Start or repeated start; a full low half lets a slave's acknowledge end first
  task automatic start();
    sda_pull = 1'b0;
    q();
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b1;
    q();
    scl = 1'b0;
  endtask
  // One bit, sampled at end of clock high
  task automatic bit_io(input logic b, output logic s);
    q();
    sda_pull = ~b;
    q();
    scl = 1'b1;
    q();
    q();
    s = sda;
    scl = 1'b0;
  endtask
  // Stop, then bus idle
  task automatic stop();
    q();
    sda_pull = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b0;
    q();
  endtask
  // Send a byte, report acknowledge
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // Take a byte, then acknowledge or not
  task automatic rd(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule // tw_master

/* File: testbench/test_two_wire_eeprom_array_core.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module test_two_wire_eeprom_array_core;
  localparam int       WR  = 200;
  localparam bit [3:0] DEV = 4'h5; // Arbitrary value
  logic       mclk;
  logic       rst_n;
  logic       scl;
  logic       sda_pull;
  wire        sda;
  logic       sda_o;
  logic       sda_oe;
  logic [2:0] strap;
  logic       wp;
  logic       wr_busy;
  int         n_errors;
  int         num_checks;
  // Open-drain wire with pull-up
  assign sda = !(sda_pull || (sda_oe && !sda_o));
  tw_core #(.WR_CYCLES(WR), .DEV_CODE(DEV)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_select_pin_0(strap[0]), .addr_select_pin_1(strap[1]),
    .addr_select_pin_2(strap[2]), .wp_i(wp), .wr_busy(wr_busy));
  tw_master i_mst (.mclk(mclk), .scl(scl), .sda_pull(sda_pull), .sda(sda));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Device address for write, then word address
  task automatic hdr(input logic [14:0] a, output logic ack);
    logic k1, k2, k3;
    i_mst.start();
    i_mst.wr({DEV, strap, 1'b0}, k1);
    i_mst.wr({1'b0, a[14:8]}, k2);
    i_mst.wr(a[7:0], k3);
    ack = k1 & k2 & k3;
  endtask
  // Random read of one byte
  task automatic rd1(input logic [14:0] a, input logic [7:0] e);
    logic       k;
    logic [7:0] d;
    hdr(a, k);
    i_mst.start();
    i_mst.wr({DEV, strap, 1'b1}, k);
    i_mst.rd(1'b0, d);
    i_mst.stop();
    chk("read data", e, d);
  endtask
  // Write cycle starts, refuses a poll, ends in bound
  task automatic wdone();
    logic k;
    int   n;
    time  t0;
    t0 = $time;
    repeat (6) @(negedge mclk);
    chk("busy", 8'h01, {7'h00, wr_busy});
    i_mst.start();
    i_mst.wr({DEV, strap, 1'b0}, k);
    i_mst.stop();
    chk("poll ack", 8'h00, {7'h00, k});
    n = 0;
    while (wr_busy === 1'b1 && n < WR + 8) begin
      @(negedge mclk);
      n++;
    end
    chk("busy end", 8'h00, {7'h00, wr_busy});
    chk("busy span", 8'h01, {7'h00, ($time - t0) <= (WR + 8) * 50});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_erased();
    rd1(15'h0000, 8'hff);
    rd1(15'h7fff, 8'hff);
  endtask
  // Lone byte merges into its group
  task automatic t_byte();
    logic k;
    hdr(15'h1235, k);
    i_mst.wr(8'h3c, k);
    i_mst.stop();
    wdone();
    rd1(15'h1234, 8'hff);
    rd1(15'h1235, 8'h3c);
    rd1(15'h1237, 8'hff);
  endtask
  // 66 bytes into one page, last two wrap
  task automatic t_page();
    logic       k;
    logic [7:0] d;
    hdr(15'h0080, k);
    for (int i = 0; i < 66; i++) begin
      i_mst.wr(8'h10 + 8'(i), k);
    end
    i_mst.stop();
    chk("data ack", 8'h01, {7'h00, k});
    wdone();
    // Sequential read across the two wrapped bytes
    hdr(15'h0080, k);
    i_mst.start();
    i_mst.wr({DEV, strap, 1'b1}, k);
    i_mst.rd(1'b1, d);
    chk("seq read 0", 8'h50, d);
    i_mst.rd(1'b0, d);
    i_mst.stop();
    chk("seq read 1", 8'h51, d);
    rd1(15'h00bf, 8'h4f);
    rd1(15'h00c0, 8'hff);
  endtask
  // Guard high refuses data, starts no cycle
  task automatic t_guard();
    logic k;
    wp = 1'b1;
    hdr(15'h0300, k);
    i_mst.wr(8'h00, k);
    i_mst.stop();
    chk("guard ack", 8'h00, {7'h00, k});
    repeat (20) @(negedge mclk);
    chk("guard busy", 8'h00, {7'h00, wr_busy});
    wp = 1'b0;
    rd1(15'h0300, 8'hff);
  endtask
  // Every strap setting, own and foreign address
  task automatic t_strap();
    logic k;
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      i_mst.start();
      i_mst.wr({DEV, 3'(s), 1'b0}, k);
      i_mst.stop();
      chk("own addr ack", 8'h01, {7'h00, k});
      i_mst.start();
      i_mst.wr({DEV, 3'(s ^ 5), 1'b0}, k);
      i_mst.stop();
      chk("other addr ack", 8'h00, {7'h00, k});
    end
    strap = 3'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Data pin only ever pulls low
  always @(negedge mclk) begin
    if (sda_oe === 1'b1 && sda_o !== 1'b0) begin
      n_errors++;
      $display("unexpected sda_o: expected 0, seen %b", sda_o);
    end
  end
  // Main sequence
  initial begin
    n_errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    strap = 3'h0;
    wp = 1'b0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    t_erased();
    t_strap();
    t_byte();
    t_page();
    t_guard();
    end_sim();
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    $display("unexpected run time: expected done, seen hang");
    end_sim();
  end
endmodule // test_two_wire_eeprom_array_core
